/* dv/iosc_chk.sv */
`timescale 1ns/1ps
module iosc_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0] cfg_osc_mode,
  input wire logic port_a_bit6_out,
  input wire logic port_a_bit6_dir_out,
  input wire logic port_a_bit7_out,
  input wire logic port_a_bit7_dir_out,
  input wire logic osc_input_pin_o,
  input wire logic osc_input_pin_oe,
  input wire logic osc_output_pin_o,
  input wire logic osc_output_pin_oe,
  input wire logic fast_src_en,
  input wire logic slow_src_en,
  input wire logic int_clk_tick,
  input wire logic pll_active,
  input wire logic [2:0] dev_clk_mult
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // strap must stay put six cycles so it has passed the two-flop sync
  wire wr = psel && penable && pwrite;
  wire rdt = psel && penable && !pwrite && paddr == 8'h00;
  wire intm = cfg_osc_mode == 4'h9 || cfg_osc_mode == 4'h8;
  sequence s_ext; !intm [*6]; endsequence
  sequence s_co; (cfg_osc_mode == 4'h9) [*6]; endsequence
  sequence s_dual; (cfg_osc_mode == 4'h8) [*6]; endsequence
  AST_FAST_EN: assert property (
    wr && paddr == 8'h04 && pwdata[6:4] != 3'h0 |-> ##2 fast_src_en)
    else $error("fast source off");
  AST_SLOW_EN: assert property (
    wr && paddr == 8'h08 && pwdata[3:0] != 4'h0 |-> ##2 slow_src_en)
    else $error("slow source off");
  AST_PLL_SEL: assert property (
    wr && paddr == 8'h04 && pwdata[6:5] != 2'b11 |-> ##2 !pll_active)
    else $error("pll on at low select");
  AST_PLL_CFG: assert property (s_ext |-> !pll_active)
    else $error("pll on in external mode");
  AST_PLL_RD: assert property (s_ext ##0 rdt |-> !prdata[6])
    else $error("pll enable reads one");
  AST_RSVD: assert property (rdt |-> !prdata[5])
    else $error("reserved bit set");
  AST_MULT: assert property (dev_clk_mult == (pll_active ? 3'h4 : 3'h1))
    else $error("multiplier mismatch");
  AST_TICK: assert property (int_clk_tick |=> !int_clk_tick)
    else $error("tick longer than a cycle");
  AST_CLKOUT: assert property (
    s_co |-> osc_output_pin_oe && osc_input_pin_oe == port_a_bit7_dir_out
    && osc_input_pin_o == port_a_bit7_out)
    else $error("clock-out pins wrong");
  AST_DUAL: assert property (
    s_dual |-> osc_output_pin_oe == port_a_bit6_dir_out
    && osc_output_pin_o == port_a_bit6_out)
    else $error("dual pins wrong");
endmodule
bind iosc_top iosc_chk u_chk (.*);

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, slow_rc_clk, er, po, ext6, ext7;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] cfg_osc_mode;
  logic osc_input_pin_i, osc_input_pin_o, osc_input_pin_oe;
  logic osc_output_pin_i, osc_output_pin_o, osc_output_pin_oe;
  logic port_a_bit6_out, port_a_bit6_dir_out, port_a_bit6_in;
  logic port_a_bit7_out, port_a_bit7_dir_out, port_a_bit7_in;
  logic fast_src_en, slow_src_en, int_clk_tick, pll_active;
  logic [2:0] dev_clk_mult;
  int n_fail, n_compared, nt, ng;
  // a pin shows its driver when enabled, else the board level
  assign osc_input_pin_i = osc_input_pin_oe ? osc_input_pin_o : ext7;
  assign osc_output_pin_i = osc_output_pin_oe ? osc_output_pin_o : ext6;
  iosc_top dut (.*);
  initial begin mclk = 0; forever #20 mclk = ~mclk; end
  // slow rc stand-in: 800 mclk period, about 31 kHz
  initial begin slow_rc_clk = 0; forever begin repeat (400) @(posedge mclk);
    slow_rc_clk <= ~slow_rc_clk; end end
  // the tests need about 89k cycles; give up at 95k
  initial begin #3_800_000; n_fail++; close_out(); end
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
  endtask
  task automatic chkr(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail++;
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(0, a, 0); chk(nm, e, rd);
  endtask
  task automatic st(input int n); repeat (n) @(posedge mclk); #1; endtask
  // counts internal ticks and clock-out toggles over n cycles
  task automatic cnt(input int n);
    nt = 0; ng = 0; po = osc_output_pin_o;
    // look just after each edge, once the registered outputs have settled
    repeat (n) begin @(posedge mclk); #1; nt += int_clk_tick; ng += (osc_output_pin_o !== po);
      po = osc_output_pin_o; end
  endtask
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; cfg_osc_mode = 4'h2;
    ext6 = 0; ext7 = 0; port_a_bit6_out = 0; port_a_bit6_dir_out = 0;
    port_a_bit7_out = 0; port_a_bit7_dir_out = 0; n_fail = 0; n_compared = 0;
    repeat (10) @(posedge mclk); rst <= 0;
    st(4);
    rdc(8'h00, 32'h0000_0000, "tuning");
    rdc(8'h04, 32'h0000_0040, "control");
    rdc(8'h08, 32'h0000_0000, "features");
    rdc(8'h0C, 32'h0000_0004, "status");
    apb(0, 8'h10, 0); chk("slverr", 1, er); chk("unmapped", 0, rd);
    $display("reset test done");
    for (int s = 1; s < 8; s++) begin
      apb(1, 8'h04, 32'(s) << 4); st(4);
      chk("fast_en", 1, fast_src_en);
      chk("slow_en", 0, slow_src_en);
      cnt(1250); chkr("ticks", (400 >> (7 - s)) - 2, (400 >> (7 - s)) + 2, nt);
    end
    apb(1, 8'h00, 32'h0000_0080); apb(1, 8'h04, 0); st(4);
    chk("fast_en", 1, fast_src_en);
    cnt(6400); chkr("div256", 7, 9, nt);
    $display("select test done");
    apb(1, 8'h04, 32'h0000_0070);
    apb(1, 8'h00, 32'h0000_000F);
    apb(0, 8'h0C, 0); chk("glide", 0, rd[12:8] == 5'h0F);
    st(25000); apb(0, 8'h0C, 0); chk("trim", 32'h0000_000F, rd[12:8]);
    cnt(1250); chkr("max", 488, 499, nt);
    apb(1, 8'h00, 32'h0000_0010);
    st(25000); cnt(1250); chkr("min", 295, 305, nt);
    apb(1, 8'h04, 0); st(4);
    chk("fast_off", 0, fast_src_en);
    chk("slow_on", 1, slow_src_en);
    cnt(6400); chkr("slow", 7, 9, nt);
    apb(1, 8'h04, 32'h0000_0070);
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h08, (i < 4) ? 32'(1) << i : 0); st(4); chk("feat", i < 4, slow_src_en);
    end
    $display("trim test done");
    apb(1, 8'h00, 32'h0000_0040); st(4); rdc(8'h00, 0, "pll_bit");
    chk("pll", 0, pll_active);
    @(posedge mclk); cfg_osc_mode <= 4'h9; port_a_bit7_out <= 1; port_a_bit7_dir_out <= 1;
    st(8); apb(1, 8'h00, 32'h0000_0040); st(4); rdc(8'h00, 32'h0000_0040, "pll_bit");
    for (int s = 0; s < 8; s++) begin
      apb(1, 8'h04, 32'(s) << 4); st(4); chk("pll", s >= 6, pll_active);
      chk("mult", (s >= 6) ? 4 : 1, dev_clk_mult);
    end
    chk("in_o", 1, osc_input_pin_o); chk("in_oe", 1, osc_input_pin_oe);
    chk("bit7_in", 1, port_a_bit7_in);
    // trim is still gliding back up from the minimum, so let it settle first
    apb(1, 8'h00, 0); st(13000); cnt(1250); chkr("fosc4", 195, 205, ng);
    @(posedge mclk); cfg_osc_mode <= 4'h8; port_a_bit6_out <= 1; port_a_bit6_dir_out <= 1;
    st(8); chk("out_o", 1, osc_output_pin_o); chk("out_oe", 1, osc_output_pin_oe);
    @(posedge mclk); port_a_bit6_dir_out <= 0; ext6 <= 1;
    st(4); chk("out_oe", 0, osc_output_pin_oe); chk("bit6_in", 1, port_a_bit6_in);
    apb(1, 8'h00, 32'h0000_0040); st(4); chk("pll", 1, pll_active);
    @(posedge mclk); cfg_osc_mode <= 4'h3;
    st(8); chk("pll", 0, pll_active); rdc(8'h00, 0, "pll_clr");
    $display("pll and pin test done");
    close_out();
  end
endmodule

/* logic/iosc_clk_if.sv */
`timescale 1ns/1ps
interface iosc_clk_if;
  logic fast_en;
  logic fast_tick;
  logic slow_en;
  logic slow_tick;
  logic [2:0] freq_sel;
  logic lf_src_sel;
  logic signed [4:0] trim_target;
  logic signed [4:0] trim_now;
  logic int_tick;
  modport nco (input fast_en, input trim_target, output fast_tick, output trim_now);
  modport div (input fast_tick, input slow_tick, input slow_en, input freq_sel,
               input lf_src_sel, output int_tick);
  modport top (output fast_en, output slow_en, output slow_tick, output freq_sel,
               output lf_src_sel, output trim_target, input fast_tick, input trim_now,
               input int_tick);
endinterface

/* logic/iosc_nco.sv */
`timescale 1ns/1ps
module iosc_nco (
  input wire logic mclk,
  input wire logic rst,
  iosc_clk_if.nco ci
);
  localparam int NCO_W_L = iosc_pkg::NCO_W;
  logic [NCO_W_L-1:0] acc_q;
  logic signed [4:0] trim_q;
  logic [9:0] glide_cnt_q;
  iosc_pkg::iosc_glide_t state_q;
  logic [NCO_W_L:0] sum;
  logic [NCO_W_L-1:0] inc;

  // frequency moves one trim step per interval, no done flag is raised
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= iosc_pkg::GL_IDLE;
      trim_q <= 5'sh00;
      glide_cnt_q <= 10'h000;
    end else begin
      case (state_q)
        iosc_pkg::GL_IDLE: begin
          glide_cnt_q <= 10'h000;
          if (trim_q != ci.trim_target) state_q <= iosc_pkg::GL_STEP;
        end
        iosc_pkg::GL_STEP: begin
          if (glide_cnt_q == iosc_pkg::GLIDE_CYC - 10'h001) begin
            glide_cnt_q <= 10'h000;
            if (trim_q < ci.trim_target) trim_q <= trim_q + 5'sh01;
            else if (trim_q > ci.trim_target) trim_q <= trim_q - 5'sh01;
            else state_q <= iosc_pkg::GL_IDLE;
          end else begin
            glide_cnt_q <= glide_cnt_q + 10'h001;
          end
        end
        default: state_q <= iosc_pkg::GL_IDLE;
      endcase
    end
  end

  // signed trim scales the phase step around the calibrated centre
  assign inc = NCO_W_L'(iosc_pkg::NCO_BASE + NCO_W_L'($signed({{19{trim_q[4]}}, trim_q})
               * $signed({1'b0, iosc_pkg::NCO_STEP})));
  assign sum = {1'b0, acc_q} + {1'b0, inc};

  // carry out of the accumulator is one fast-source cycle
  always_ff @(posedge mclk) begin
    if (rst || !ci.fast_en) begin
      acc_q <= '0;
      ci.fast_tick <= 1'b0;
    end else begin
      acc_q <= sum[NCO_W_L-1:0];
      ci.fast_tick <= sum[NCO_W_L];
    end
  end

  assign ci.trim_now = trim_q;
endmodule

/* logic/iosc_pkg.sv */
// Functional notes
// - fast source 8 MHz, postscaled 31 kHz-4 MHz
// - fast source on for 125 kHz-8 MHz selections
// - slow RC runs when selected or features on
// - frequency select picks direct, slow, or postscaled
// - clock-out mode: Fosc/4 out, input pin is GPIO
// - dual-I/O mode frees both oscillator pins
// - trim glides to new frequency within 1 ms
// - trim never touches slow RC source
// - enabled PLL multiplies internal clock by four
// - PLL permitted only for internal modes 1001/1000
// - PLL works only at select 111 or 110
// - unavailable PLL enable forced zero, writes ignored
// - tuning bit 7 picks divided-fast or slow RC
// - tuning bit 6 enables the PLL
// - five-bit signed trim, 0 centre, 01111 max
// - select encoding 111..000, reset value 100
package iosc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_TUNING = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_FEATURES = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  // tuning register fields
  localparam int TUNE_LF_SRC_BIT = 7;
  localparam int TUNE_PLL_EN_BIT = 6;
  localparam int TUNE_TRIM_MSB = 4;
  // control register field
  localparam int CTL_FSEL_LSB = 4;
  localparam logic [7:0] TUNING_RESET = 8'h00;
  localparam logic [2:0] FSEL_RESET = 3'h4;
  localparam logic [3:0] FEATURES_RESET = 4'h0;
  // frequency select codes
  localparam logic [2:0] FSEL_8M = 3'h7;
  localparam logic [2:0] FSEL_4M = 3'h6;
  localparam logic [2:0] FSEL_31K = 3'h0;
  // oscillator configuration codes
  localparam logic [3:0] CFG_INT_CLKOUT = 4'h9;
  localparam logic [3:0] CFG_INT_DUAL_IO = 4'h8;
  localparam logic [2:0] PLL_MULT = 3'h4;
  // timing
  localparam longint MCLK_KHZ = 25000;
  localparam longint FAST_KHZ = 8000;
  localparam longint GLIDE_TIME_US = 1000;
  localparam longint TRIM_SPAN = 31;
  localparam int NCO_W = 24;
  localparam logic [NCO_W-1:0] NCO_BASE = NCO_W'((FAST_KHZ << NCO_W) / MCLK_KHZ);
  localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(NCO_BASE >> 6);
  localparam longint GLIDE_CYC_RAW = (MCLK_KHZ * GLIDE_TIME_US) / (1000 * TRIM_SPAN);
  localparam logic [9:0] GLIDE_CYC = 10'((GLIDE_CYC_RAW < 1) ? 1 : GLIDE_CYC_RAW);

  typedef enum logic [0:0] {GL_IDLE = 1'b0, GL_STEP = 1'b1} iosc_glide_t;

  // ones mark divider bits that must all be set for an output tick
  function automatic logic [7:0] iosc_div_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h00;
    case (sel)
      3'h7: m = 8'h00;
      3'h6: m = 8'h01;
      3'h5: m = 8'h03;
      3'h4: m = 8'h07;
      3'h3: m = 8'h0F;
      3'h2: m = 8'h1F;
      3'h1: m = 8'h3F;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction
endpackage

/* logic/iosc_postscaler.sv */
`timescale 1ns/1ps
module iosc_postscaler (
  input wire logic mclk,
  input wire logic rst,
  iosc_clk_if.div ci
);
  logic [7:0] div_q;
  logic [7:0] mask;

  // free-running divider; lower taps give the faster postscaled rates
  always_ff @(posedge mclk) begin
    if (rst) div_q <= 8'h00;
    else if (ci.fast_tick) div_q <= div_q + 8'h01;
  end

  assign mask = iosc_pkg::iosc_div_mask(ci.freq_sel);

  // lowest setting uses /256 or the slow RC per the source bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      ci.int_tick <= 1'b0;
    end else if (ci.freq_sel == iosc_pkg::FSEL_31K && !ci.lf_src_sel) begin
      ci.int_tick <= ci.slow_tick & ci.slow_en;
    end else begin
      ci.int_tick <= ci.fast_tick && ((div_q & mask) == mask);
    end
  end
endmodule

/* logic/iosc_top.sv */
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module iosc_top (
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration and slow oscillator pins
  input wire logic [3:0] cfg_osc_mode,
  input wire logic slow_rc_clk,
  // oscillator pins
  input wire logic osc_input_pin_i,
  output logic osc_input_pin_o,
  output logic osc_input_pin_oe,
  input wire logic osc_output_pin_i,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe,
  // port a side
  input wire logic port_a_bit6_out,
  input wire logic port_a_bit6_dir_out,
  output logic port_a_bit6_in,
  input wire logic port_a_bit7_out,
  input wire logic port_a_bit7_dir_out,
  output logic port_a_bit7_in,
  // clock results
  output logic fast_src_en,
  output logic slow_src_en,
  output logic int_clk_tick,
  output logic pll_active,
  output logic [2:0] dev_clk_mult
);
  iosc_clk_if ci ();

  logic [7:0] tuning_q;
  logic [2:0] fsel_q;
  logic [3:0] features_q;
  logic [3:0] cfg_meta_q;
  logic [3:0] cfg_q;
  logic slow_meta_q;
  logic slow_sync_q;
  logic slow_prev_q;
  logic [1:0] pin6_meta_q;
  logic [1:0] pin6_sync_q;
  logic fosc_cnt_q;
  logic fosc_q;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic wr_en;
  logic pll_mode_ok;
  logic pll_freq_ok;
  logic fast_need;
  logic slow_need;
  logic int_mode;

  // pins and straps come from outside mclk, so two flops each
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_meta_q <= 4'h0;
      cfg_q <= 4'h0;
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
      pin6_meta_q <= 2'h0;
      pin6_sync_q <= 2'h0;
    end else begin
      cfg_meta_q <= cfg_osc_mode;
      cfg_q <= cfg_meta_q;
      slow_meta_q <= slow_rc_clk;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
      pin6_meta_q <= {osc_input_pin_i, osc_output_pin_i};
      pin6_sync_q <= pin6_meta_q;
    end
  end

  // apb decode; every access completes in its first access cycle
  assign addr_ok = (paddr == iosc_pkg::OFF_TUNING) || (paddr == iosc_pkg::OFF_CONTROL)
                 || (paddr == iosc_pkg::OFF_FEATURES) || (paddr == iosc_pkg::OFF_STATUS);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;

  // pll permission from configuration and selected frequency
  assign pll_mode_ok = (cfg_q == iosc_pkg::CFG_INT_CLKOUT)
                     || (cfg_q == iosc_pkg::CFG_INT_DUAL_IO);
  assign pll_freq_ok = (fsel_q == iosc_pkg::FSEL_8M)
                     || (fsel_q == iosc_pkg::FSEL_4M);
  assign int_mode = pll_mode_ok;

  // tuning register; bit 5 is not stored and reads zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      tuning_q <= iosc_pkg::TUNING_RESET;
    end else begin
      if (wr_en && paddr == iosc_pkg::OFF_TUNING) begin
        tuning_q[iosc_pkg::TUNE_LF_SRC_BIT] <= pwdata[iosc_pkg::TUNE_LF_SRC_BIT];
        tuning_q[iosc_pkg::TUNE_PLL_EN_BIT] <= pwdata[iosc_pkg::TUNE_PLL_EN_BIT]
                                               & pll_mode_ok;
        tuning_q[iosc_pkg::TUNE_TRIM_MSB:0] <= pwdata[iosc_pkg::TUNE_TRIM_MSB:0];
      end else if (!pll_mode_ok) begin
        tuning_q[iosc_pkg::TUNE_PLL_EN_BIT] <= 1'b0;
      end
      tuning_q[5] <= 1'b0;
    end
  end

  // frequency select, defaults to the 1 MHz setting
  always_ff @(posedge mclk) begin
    if (rst) fsel_q <= iosc_pkg::FSEL_RESET;
    else if (wr_en && paddr == iosc_pkg::OFF_CONTROL)
      fsel_q <= pwdata[iosc_pkg::CTL_FSEL_LSB +: 3];
  end

  // power-up timer, fail-safe monitor, watchdog and two-speed enables
  always_ff @(posedge mclk) begin
    if (rst) features_q <= iosc_pkg::FEATURES_RESET;
    else if (wr_en && paddr == iosc_pkg::OFF_FEATURES) features_q <= pwdata[3:0];
  end

  // read data is captured in the setup cycle so prdata is a flop
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      iosc_pkg::OFF_TUNING: rdata_d = {24'h00_0000, tuning_q};
      iosc_pkg::OFF_CONTROL: rdata_d = {25'h000_0000, fsel_q, 4'h0};
      iosc_pkg::OFF_FEATURES: rdata_d = {28'h000_0000, features_q};
      iosc_pkg::OFF_STATUS: rdata_d = {19'h0_0000, ci.trim_now, 3'h0,
                                       pll_active, slow_src_en, fast_src_en, 2'h0};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (psel && !penable) prdata <= rdata_d;
  end

  // source enables; divided-fast 31 kHz still needs the fast source
  assign fast_need = (fsel_q != iosc_pkg::FSEL_31K)
                   || tuning_q[iosc_pkg::TUNE_LF_SRC_BIT];
  assign slow_need = ((fsel_q == iosc_pkg::FSEL_31K) && !tuning_q[iosc_pkg::TUNE_LF_SRC_BIT])
                   || (features_q != 4'h0);

  always_ff @(posedge mclk) begin
    if (rst) begin
      fast_src_en <= 1'b0;
      slow_src_en <= 1'b0;
      pll_active <= 1'b0;
      dev_clk_mult <= 3'h1;
    end else begin
      fast_src_en <= fast_need;
      slow_src_en <= slow_need;
      pll_active <= tuning_q[iosc_pkg::TUNE_PLL_EN_BIT] & pll_mode_ok & pll_freq_ok;
      dev_clk_mult <= (tuning_q[iosc_pkg::TUNE_PLL_EN_BIT] & pll_mode_ok & pll_freq_ok)
                      ? iosc_pkg::PLL_MULT : 3'h1;
    end
  end

  // wiring toward the two clock submodules
  assign ci.fast_en = fast_src_en;
  assign ci.slow_en = slow_src_en;
  assign ci.slow_tick = slow_sync_q & ~slow_prev_q;
  assign ci.freq_sel = fsel_q;
  assign ci.lf_src_sel = tuning_q[iosc_pkg::TUNE_LF_SRC_BIT];
  assign ci.trim_target = $signed(tuning_q[iosc_pkg::TUNE_TRIM_MSB:0]);

  iosc_nco u_nco (
    .mclk(mclk),
    .rst(rst),
    .ci(ci)
  );

  iosc_postscaler u_post (
    .mclk(mclk),
    .rst(rst),
    .ci(ci)
  );

  assign int_clk_tick = ci.int_tick;

  // quarter-rate output: one toggle per two base ticks, or per tick under
  // the pll; the pll case is only an approximation at this sample rate
  always_ff @(posedge mclk) begin
    if (rst) begin
      fosc_cnt_q <= 1'b0;
      fosc_q <= 1'b0;
    end else if (ci.int_tick) begin
      fosc_cnt_q <= ~fosc_cnt_q;
      if (fosc_cnt_q || pll_active) fosc_q <= ~fosc_q;
    end
  end

  // pin routing, internal modes only: clock-out mode drives the output pin, port a owns the rest
  always_comb begin
    osc_input_pin_o = 1'b0;
    osc_input_pin_oe = 1'b0;
    osc_output_pin_o = 1'b0;
    osc_output_pin_oe = 1'b0;
    port_a_bit7_in = 1'b0;
    port_a_bit6_in = 1'b0;
    if (int_mode) begin
      osc_input_pin_o = port_a_bit7_out;
      osc_input_pin_oe = port_a_bit7_dir_out;
      port_a_bit7_in = pin6_sync_q[1];
      if (cfg_q == iosc_pkg::CFG_INT_DUAL_IO) begin
        osc_output_pin_o = port_a_bit6_out;
        osc_output_pin_oe = port_a_bit6_dir_out;
        port_a_bit6_in = pin6_sync_q[0];
      end else begin
        osc_output_pin_o = fosc_q;
        osc_output_pin_oe = 1'b1;
      end
    end
  end
endmodule
